// ---- core/bwc_defs.vh ----
// Offsets, field positions, reset values and mode encodings of the bank
`ifndef BWC_DEFS_VH
`define BWC_DEFS_VH
`define BWC_ADDR_W 7
`define BWC_OFF_TMC 7'h04
`define BWC_OFF_SPC 7'h05
`define BWC_OFF_IWC 7'h06
`define BWC_OFF_EWC 7'h07
`define BWC_OFF_WDC 7'h03
`define BWC_RST_TMC 8'h20
`define BWC_RST_SPC 8'h00
`define BWC_RST_IWC 8'h00
`define BWC_RST_EWC 8'h07
`define BWC_WMASK_TMC 8'hFB
`define BWC_WMASK_SPC 8'h20
`define BWC_WMASK_IWC 8'hC4
`define BWC_WMASK_EWC 8'hA7
`define BWC_FS_TMC_KEEP 8'hE0
`define BWC_FS_TMC_SET 8'h09
`define BWC_FS_EWC_KEEP 8'hA0
`define BWC_FS_EWC_SET 8'h07
`define BWC_RS_EWC_KEEP 8'hA7
`define BWC_RS_IWC_KEEP 8'hC0
`define BWC_BIT_FLASH 7
`define BWC_BIT_LSM 6
`define BWC_BIT_TXDTO 5
`define BWC_BIT_PEAK 5
`define BWC_BIT_T2WK 7
`define BWC_BIT_T1WK 6
`define BWC_BIT_WDOFF 2
`define BWC_BIT_INTG 7
`define BWC_BIT_MEAS 5
`define BWC_BIT_WKC 2
`define BWC_BIT_WKB 1
`define BWC_BIT_WKA 0
`define BWC_BIT_WDOFF_LO 6
`define BWC_MODE_OFF 2'h0
`define BWC_MODE_WAKE 2'h1
`define BWC_MODE_RXONLY 2'h2
`define BWC_MODE_NORMAL 2'h3
`endif

// ---- core/bwc_regs.v ----
// Bus and wake control register bank of the serial interface
`timescale 1ns/1ns
`include "bwc_defs.vh"

module bwc_regs (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire soft_reset_i,
  input wire restart_i,
  input wire fail_safe_entry_i,
  input wire mode_init_i,
  input wire mode_normal_i,
  input wire mode_stop_i,
  input wire chip_select_n_i,
  input wire wr_en_i,
  input wire [6:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire [6:0] rd_addr_i,
  input wire hw_lin_mode_we_i,
  input wire [1:0] hw_lin_mode_i,
  input wire hw_can_mode_we_i,
  input wire [1:0] hw_can_mode_i,
  input wire hw_wdoff_we_i,
  input wire hw_wdoff_i,
  input wire stop_watchdog_off_lo_i,
  input wire [7:0] status_events_i,
  input wire [7:0] wake_events_i,
  output reg [7:0] rd_data_o,
  output reg rd_hit_o,
  output reg spi_fail_o,
  output reg flash_mode_o,
  output reg low_slope_select_o,
  output reg transmit_timeout_enable_o,
  output reg [1:0] lin_port_mode_o,
  output reg [1:0] can_mode_o,
  output reg peak_current_threshold_o,
  output reg second_timer_wake_enable_o,
  output reg first_timer_wake_enable_o,
  output reg watchdog_stop_off_o,
  output reg int_request_o,
  output reg measure_active_o,
  output reg wake_input_a_enable_o,
  output reg wake_input_b_enable_o,
  output reg wake_input_c_enable_o,
  output reg lin_wake_capable_o,
  output reg can_wake_capable_o
);

  // ==========================================================
  // Chip select synchroniser and rising edge
  // ==========================================================
  reg cs_meta_q;
  reg cs_sync_q;
  reg cs_last_q;
  wire cs_rise;

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_last_q <= 1'b1;
    end else begin
      cs_meta_q <= chip_select_n_i;
      cs_sync_q <= cs_meta_q;
      cs_last_q <= cs_sync_q;
    end
  end

  // Only the second and third flops feed logic; the first may still be settling
  assign cs_rise = cs_sync_q & ~cs_last_q;

  // ==========================================================
  // Register storage
  // ==========================================================
  reg [7:0] tmc_q;
  reg [7:0] tmc_d;
  reg [7:0] spc_q;
  reg [7:0] spc_d;
  reg [7:0] iwc_q;
  reg [7:0] iwc_d;
  reg [7:0] ewc_q;
  reg [7:0] ewc_d;
  reg spi_fail_d;

  // Merges a write into the writable positions only
  function [7:0] bwc_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] wmask;
    begin
      bwc_merge = (old_v & ~wmask) | (new_v & wmask);
    end
  endfunction

  // True when a strobed access targets the given offset
  function bwc_hit;
    input strobe;
    input [6:0] addr;
    input [6:0] offset;
    begin
      bwc_hit = strobe && (addr == offset);
    end
  endfunction

  // True for the wake-capable encoding of a transceiver mode field
  function bwc_is_wake;
    input [1:0] mode;
    begin
      bwc_is_wake = (mode == `BWC_MODE_WAKE);
    end
  endfunction

  // Wake inputs a and b lose their enables while measurement owns them
  function bwc_wake_gate;
    input enable;
    input measure;
    begin
      bwc_wake_gate = enable & ~measure;
    end
  endfunction

  wire wr_tmc = bwc_hit(wr_en_i, wr_addr_i, `BWC_OFF_TMC);
  wire wr_spc = bwc_hit(wr_en_i, wr_addr_i, `BWC_OFF_SPC);
  wire wr_iwc = bwc_hit(wr_en_i, wr_addr_i, `BWC_OFF_IWC);
  wire wr_ewc = bwc_hit(wr_en_i, wr_addr_i, `BWC_OFF_EWC);

  always @* begin
    tmc_d = tmc_q;
    spc_d = spc_q;
    iwc_d = iwc_q;
    ewc_d = ewc_q;
    // Stop-mode peak writes are dropped silently, so this never sets
    spi_fail_d = 1'b0;
    if (wr_tmc)
      tmc_d = bwc_merge(tmc_q, wr_data_i, `BWC_WMASK_TMC);
    if (wr_spc && (mode_init_i || mode_normal_i))
      spc_d = bwc_merge(spc_q, wr_data_i, `BWC_WMASK_SPC);
    if (wr_iwc)
      iwc_d = bwc_merge(iwc_q, wr_data_i, `BWC_WMASK_IWC);
    if (wr_ewc)
      ewc_d = bwc_merge(ewc_q, wr_data_i, `BWC_WMASK_EWC);
    // Hardware updates win over a software write in the same cycle
    if (hw_lin_mode_we_i)
      tmc_d[4:3] = hw_lin_mode_i;
    if (hw_can_mode_we_i)
      tmc_d[1:0] = hw_can_mode_i;
    if (hw_wdoff_we_i)
      iwc_d[`BWC_BIT_WDOFF] = hw_wdoff_i;
    if (restart_i) begin
      spc_d = spc_q & `BWC_WMASK_SPC;
      iwc_d = iwc_q & `BWC_RS_IWC_KEEP;
      ewc_d = ewc_q & `BWC_RS_EWC_KEEP;
    end
    if (fail_safe_entry_i) begin
      tmc_d = (tmc_q & `BWC_FS_TMC_KEEP) | `BWC_FS_TMC_SET;
      ewc_d = (ewc_q & `BWC_FS_EWC_KEEP) | `BWC_FS_EWC_SET;
    end
    tmc_d[2] = 1'b0;
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i || soft_reset_i) begin
      tmc_q <= `BWC_RST_TMC;
      spc_q <= `BWC_RST_SPC;
      iwc_q <= `BWC_RST_IWC;
      ewc_q <= `BWC_RST_EWC;
      spi_fail_o <= 1'b0;
    end else begin
      tmc_q <= tmc_d;
      spc_q <= spc_d;
      iwc_q <= iwc_d;
      ewc_q <= ewc_d;
      spi_fail_o <= spi_fail_d;
    end
  end

  // ==========================================================
  // Read port, reserved positions masked to zero
  // ==========================================================
  reg [7:0] rd_data_d;
  reg rd_hit_d;

  always @* begin
    rd_data_d = 8'h00;
    rd_hit_d = 1'b1;
    case (rd_addr_i)
      `BWC_OFF_TMC: rd_data_d = tmc_q & `BWC_WMASK_TMC;
      `BWC_OFF_SPC: rd_data_d = spc_q & `BWC_WMASK_SPC;
      `BWC_OFF_IWC: rd_data_d = iwc_q & `BWC_WMASK_IWC;
      `BWC_OFF_EWC: rd_data_d = ewc_q & `BWC_WMASK_EWC;
      default: rd_hit_d = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rd_data_o <= 8'h00;
      rd_hit_o <= 1'b0;
    end else begin
      rd_data_o <= rd_data_d;
      rd_hit_o <= rd_hit_d;
    end
  end

  // ==========================================================
  // Derived controls
  // ==========================================================
  // LIN options are latched only at frame end so that a half-shifted
  // frame never reaches the transceiver
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flash_mode_o <= 1'b0;
      low_slope_select_o <= 1'b0;
      transmit_timeout_enable_o <= 1'b1;
    end else if (cs_rise) begin
      flash_mode_o <= tmc_q[`BWC_BIT_FLASH];
      low_slope_select_o <= tmc_q[`BWC_BIT_LSM];
      transmit_timeout_enable_o <= tmc_q[`BWC_BIT_TXDTO];
    end
  end

  // ==========================================================
  // Transceiver modes and bus wake
  // ==========================================================
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      lin_port_mode_o <= `BWC_MODE_OFF;
      can_mode_o <= `BWC_MODE_OFF;
      lin_wake_capable_o <= 1'b0;
      can_wake_capable_o <= 1'b0;
    end else begin
      lin_port_mode_o <= tmc_q[4:3];
      can_mode_o <= tmc_q[1:0];
      // Bus wake comes only from the wake-capable encoding
      lin_wake_capable_o <= bwc_is_wake(tmc_q[4:3]);
      can_wake_capable_o <= bwc_is_wake(tmc_q[1:0]);
    end
  end

  // ==========================================================
  // Supply, timer and stop-mode watchdog controls
  // ==========================================================
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      peak_current_threshold_o <= 1'b0;
      second_timer_wake_enable_o <= 1'b0;
      first_timer_wake_enable_o <= 1'b0;
      watchdog_stop_off_o <= 1'b0;
    end else begin
      peak_current_threshold_o <= spc_q[`BWC_BIT_PEAK];
      second_timer_wake_enable_o <= iwc_q[`BWC_BIT_T2WK];
      first_timer_wake_enable_o <= iwc_q[`BWC_BIT_T1WK];
      // Either deactivation bit turns the stop-mode watchdog off
      watchdog_stop_off_o <= mode_stop_i &
        (iwc_q[`BWC_BIT_WDOFF] | stop_watchdog_off_lo_i);
    end
  end

  // ==========================================================
  // External wake inputs, measurement and interrupt request
  // ==========================================================
  // Status events reach the interrupt only when global mode is chosen
  wire [7:0] int_sources = ewc_q[`BWC_BIT_INTG] ?
    (status_events_i | wake_events_i) : wake_events_i;

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      measure_active_o <= 1'b0;
      wake_input_a_enable_o <= 1'b0;
      wake_input_b_enable_o <= 1'b0;
      wake_input_c_enable_o <= 1'b0;
      int_request_o <= 1'b0;
    end else begin
      measure_active_o <= ewc_q[`BWC_BIT_MEAS] & mode_normal_i;
      wake_input_a_enable_o <= bwc_wake_gate(ewc_q[`BWC_BIT_WKA],
        ewc_q[`BWC_BIT_MEAS]);
      wake_input_b_enable_o <= bwc_wake_gate(ewc_q[`BWC_BIT_WKB],
        ewc_q[`BWC_BIT_MEAS]);
      wake_input_c_enable_o <= ewc_q[`BWC_BIT_WKC];
      int_request_o <= |int_sources;
    end
  end

endmodule // bwc_regs

// ---- dv/bwc_props.sv ----
// Port assertions of the bus and wake control bank
`timescale 1ns/1ns
module bwc_props (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire wr_en_i,
  input wire mode_init_i,
  input wire mode_normal_i,
  input wire mode_stop_i,
  input wire soft_reset_i,
  input wire fail_safe_entry_i,
  input wire [6:0] wr_addr_i,
  input wire [6:0] rd_addr_i,
  input wire [7:0] rd_data_o,
  input wire rd_hit_o,
  input wire spi_fail_o,
  input wire lin_wake_capable_o,
  input wire can_wake_capable_o,
  input wire measure_active_o,
  input wire [1:0] lin_port_mode_o,
  input wire [1:0] can_mode_o,
  input wire peak_current_threshold_o,
  input wire watchdog_stop_off_o,
  input wire wake_input_a_enable_o,
  input wire wake_input_b_enable_o,
  input wire wake_input_c_enable_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  bus_wake_a: assert property (
    lin_wake_capable_o == (lin_port_mode_o == 2'h1)) else $error("bus wake");
  can_wake_a: assert property (
    can_wake_capable_o == (can_mode_o == 2'h1)) else $error("can wake");
  meas_block_a: assert property (measure_active_o |->
    !wake_input_a_enable_o && !wake_input_b_enable_o) else $error("meas");
  wdog_stop_a: assert property (
    watchdog_stop_off_o |-> $past(mode_stop_i)) else $error("wdog off");
  fail_safe_a: assert property (fail_safe_entry_i && !soft_reset_i |->
    ##2 lin_port_mode_o == 2'h1 && can_mode_o == 2'h1 &&
    wake_input_c_enable_o) else $error("fail safe");
  map_hit_a: assert property (
    rd_addr_i[6:2] == 5'h01 |=> rd_hit_o) else $error("hit");
  unmapped_a: assert property (rd_addr_i[6:2] != 5'h01 |=>
    !rd_hit_o && rd_data_o == 8'h00) else $error("unmapped");
  no_fail_a: assert property (!spi_fail_o) else $error("fail flag");
  peak_stop_a: assert property (wr_en_i && wr_addr_i == 7'h05 &&
    !mode_init_i && !mode_normal_i && !soft_reset_i |=>
    ##1 $stable(peak_current_threshold_o)) else $error("peak");
endmodule // bwc_props
bind bwc_regs bwc_props u_props (.*);

// ---- dv/bwc_host.sv ----
// Host model driving frames and reads into the bank
`timescale 1ns/1ns
module bwc_host (
  input wire sys_clk_i,
  input wire [7:0] rd_data_i,
  output reg chip_select_n_o = 1'b1,
  output reg wr_en_o = 1'b0,
  output reg [6:0] addr_o = 7'h00,
  output reg [7:0] data_o = 8'h00
);
  // Data turns to its inverse once the strobe has gone
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(negedge sys_clk_i);
      chip_select_n_o = 1'b0;
      addr_o = a;
      data_o = d;
      wr_en_o = 1'b1;
      @(negedge sys_clk_i);
      wr_en_o = 1'b0;
      data_o = ~d;
      repeat (7) @(negedge sys_clk_i);
      chip_select_n_o = 1'b1;
      repeat (5) @(negedge sys_clk_i);
    end
  endtask
  task rd(input [6:0] a, output [7:0] d);
    begin
      @(negedge sys_clk_i);
      addr_o = a;
      @(negedge sys_clk_i);
      d = rd_data_i;
    end
  endtask
endmodule // bwc_host

// ---- dv/bwc_regs_bench.sv ----
// Self-checking bench of the bus and wake control bank
`timescale 1ns/1ns
module bwc_regs_bench;
  localparam [31:0] RV = 32'h07000020;
  localparam [31:0] MK = 32'hA7C420FB;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [6:0] c = 7'h00;
  reg [7:0] h = 8'h00;
  reg [15:0] e = 16'h0000;
  reg [7:0] r;
  reg [6:0] i;
  wire cs_n, we;
  wire [6:0] adr;
  wire [7:0] wd, rdat;
  wire [15:0] q;
  integer n_errors = 0;
  integer checked = 0;
  always #50 clk = ~clk;
  bwc_host host (.sys_clk_i(clk), .rd_data_i(rdat), .chip_select_n_o(cs_n),
    .wr_en_o(we), .addr_o(adr), .data_o(wd));
  bwc_regs DUT (.sys_clk_i(clk), .resetn_i(rst_n), .soft_reset_i(c[6]),
    .restart_i(c[5]), .fail_safe_entry_i(c[4]), .mode_init_i(c[3]),
    .mode_normal_i(c[2]), .mode_stop_i(c[1]), .chip_select_n_i(cs_n),
    .wr_en_i(we), .wr_addr_i(adr), .wr_data_i(wd), .rd_addr_i(adr),
    .hw_lin_mode_we_i(h[0]), .hw_lin_mode_i(h[2:1]), .hw_can_mode_we_i(h[3]),
    .hw_can_mode_i(h[5:4]), .hw_wdoff_we_i(h[6]), .hw_wdoff_i(h[7]),
    .stop_watchdog_off_lo_i(c[0]), .status_events_i(e[7:0]),
    .wake_events_i(e[15:8]), .rd_data_o(rdat), .rd_hit_o(), .spi_fail_o(),
    .flash_mode_o(q[15]), .low_slope_select_o(q[14]),
    .transmit_timeout_enable_o(q[13]), .lin_port_mode_o(q[12:11]),
    .can_mode_o(q[10:9]), .peak_current_threshold_o(q[8]),
    .second_timer_wake_enable_o(q[7]), .first_timer_wake_enable_o(q[6]),
    .watchdog_stop_off_o(q[5]), .int_request_o(q[4]), .measure_active_o(q[3]),
    .wake_input_a_enable_o(q[2]), .wake_input_b_enable_o(q[1]),
    .wake_input_c_enable_o(q[0]), .lin_wake_capable_o(),
    .can_wake_capable_o());
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [6:0] a, input [7:0] x);
    begin
      host.rd(a, r);
      chk({8'h00, r}, {8'h00, x});
    end
  endtask
  task pulse(input [6:0] m);
    begin
      c = c | m;
      @(negedge clk);
      c = c & ~m;
    end
  endtask
  task settle;
    repeat (3) @(negedge clk);
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    c = 7'h08;
    for (i = 7'h04; i < 7'h08; i = i + 7'h01) begin
      rc(i, RV[8*i-32 +: 8]);
      host.wr(i, 8'hFF);
      rc(i, MK[8*i-32 +: 8]);
    end
    rc(7'h10, 8'h00);
    chk(q[15:13], 3'h7);
    $display("test masks done");
    c = 7'h04;
    settle;
    chk(q[3:0], 4'h9);
    host.wr(7'h07, 8'h07);
    chk(q[4:0], 5'h07);
    e = 16'h0100;
    settle;
    chk(q[4], 1'b1);
    e = 16'h0001;
    settle;
    chk(q[4], 1'b0);
    host.wr(7'h07, 8'h87);
    chk(q[4], 1'b1);
    e = 16'h0000;
    c = 7'h02;
    settle;
    chk(q[7:5], 3'h7);
    h = 8'h40;
    @(negedge clk);
    h = 8'h00;
    settle;
    chk(q[5], 1'b0);
    c = 7'h03;
    settle;
    chk(q[5], 1'b1);
    host.wr(7'h05, 8'h00);
    rc(7'h05, 8'h20);
    c = 7'h04;
    host.wr(7'h05, 8'h00);
    chk(q[8], 1'b0);
    host.wr(7'h05, 8'h20);
    chk(q[8], 1'b1);
    pulse(7'h20);
    rc(7'h05, 8'h20);
    $display("test wake done");
    for (i = 7'h00; i < 7'h04; i = i + 7'h01) begin
      host.wr(7'h04, {3'h0, i[1:0], 1'b0, i[1:0]});
      chk(q[12:9], {i[1:0], i[1:0]});
    end
    chk(q[15:13], 3'h0);
    h = 8'h2B;
    @(negedge clk);
    h = 8'h00;
    rc(7'h04, 8'h0A);
    host.wr(7'h04, 8'hE2);
    host.wr(7'h07, 8'h20);
    pulse(7'h10);
    rc(7'h04, 8'hE9);
    rc(7'h07, 8'h27);
    pulse(7'h40);
    rc(7'h05, 8'h00);
    rc(7'h04, 8'h20);
    rc(7'h07, 8'h07);
    $display("test modes done");
    summarize;
  end
endmodule // bwc_regs_bench
